/* File: rtl/daqc_pkg.sv */
// Constants, carriers and state layout of the acquisition-card register block.
// Assumes a 100 MHz bus clock and a host-side bus target interface with
// active-low frame, ready and select strobes.
package daqc_pkg;

  // ****************************************************************
  // Register offsets inside the claimed window
  // ****************************************************************
  localparam logic [5:0] OFF_CNT0     = 6'h00;  // Counter zero port
  localparam logic [5:0] OFF_CNT1     = 6'h04;  // Counter one port
  localparam logic [5:0] OFF_CNT2     = 6'h08;  // Counter two port
  localparam logic [5:0] OFF_TMODE    = 6'h0C;  // Timer mode control word
  localparam logic [5:0] OFF_RESULT   = 6'h10;  // Result read / analog out one
  localparam logic [5:0] OFF_DA2      = 6'h14;  // Analog out two
  localparam logic [5:0] OFF_STAT     = 6'h18;  // Status read / control write
  localparam logic [5:0] OFF_DIO      = 6'h1C;  // Digital in / out
  localparam logic [5:0] OFF_SOFTTRIG = 6'h20;  // Software conversion strobe
  localparam logic [5:0] OFF_GAIN     = 6'h24;  // Gain and channel queue
  localparam logic [5:0] OFF_BURST    = 6'h28;  // Burst count
  localparam logic [5:0] OFF_SCAN     = 6'h2C;  // Scan setup
  localparam logic [5:0] OFF_FUNC     = 6'h30;  // Conversion function
  localparam logic [5:0] OFF_FCLR     = 6'h34;  // Sample queue clear
  localparam logic [5:0] OFF_IRQ      = 6'h38;  // Irq setup read back / irq setup

  // ****************************************************************
  // Bus commands accepted by the target
  // ****************************************************************
  localparam logic [3:0] CMD_IORD = 4'h2;
  localparam logic [3:0] CMD_IOWR = 4'h3;
  localparam logic [3:0] CMD_MRD  = 4'h6;
  localparam logic [3:0] CMD_MWR  = 4'h7;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTL_TMRTR   = 2;   // Pacer is the conversion trigger
  localparam int CTL_EXTG    = 4;   // Pacer gate from external pin
  localparam int CTL_SOFTG   = 5;   // Software pacer gate level
  localparam int FUNC_C0EXT  = 0;   // Counter zero clock from external pin
  localparam int ST_NEMPTY   = 6;   // Queue not empty
  localparam int ST_NHFULL   = 7;   // Queue below half
  localparam int ST_NFULL    = 8;   // Queue not full
  localparam int RESULT_MSB  = 15;  // Top bit of the conversion result
  localparam int RESULT_LSB  = 4;   // Bottom bit of the conversion result

  // ****************************************************************
  // Timing and sizes
  // ****************************************************************
  localparam int SYS_PERIOD_NS      = 10;   // Bus clock period
  localparam int TIMEBASE_PERIOD_NS = 250;  // Pacer time base period
  localparam int TB_DIV_INT         = TIMEBASE_PERIOD_NS / SYS_PERIOD_NS;
  localparam logic [4:0] TB_DIV     = 5'(TB_DIV_INT);
  localparam int FIFO_DEPTH         = 1024;
  localparam int FIFO_WIDTH         = 16;
  localparam int FIFO_LW            = $clog2(FIFO_DEPTH) + 1;

  // ****************************************************************
  // Carriers and state
  // ****************************************************************
  typedef struct packed {
    logic        frameN;  // Frame, active low
    logic        irdyN;   // Initiator ready, active low
    logic [3:0]  cbeN;    // Command / byte enables, active low
    logic [31:0] ad;      // Address-data lines as seen on the bus
  } daqc_bus_in_t;

  typedef struct packed {
    logic [31:0] ad;       // Driven read data
    logic        adOe;     // Data lines driven
    logic        trdyN;    // Target ready, active low
    logic        devselN;  // Device select, active low
    logic        stopN;    // Stop, active low
    logic        ctlOe;    // Control strobes driven
  } daqc_bus_out_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SEL  = 5'b00010,
    ST_XFER = 5'b00100,
    ST_HOLD = 5'b01000,
    ST_TURN = 5'b10000
  } daqc_bus_state_t;

  typedef struct packed {
    daqc_bus_state_t      st;
    logic                 wr;
    logic [5:0]           off;
    daqc_bus_out_t        bus;
    logic [2:0][15:0]     cnt;
    logic [2:0][15:0]     reload;
    logic [2:0][5:0]      mode;
    logic [2:0]           armed;
    logic [4:0]           tbDiv;
    logic                 tbTick;
    logic                 extPrev;
    logic [2:0]           pulse;
    logic                 c0Out;
    logic [11:0]          daOne;
    logic [11:0]          daTwo;
    logic [7:0]           ctl;
    logic [3:0]           dout;
    logic [15:0]          gain;
    logic [7:0]           burst;
    logic [7:0]           scan;
    logic [7:0]           func;
    logic [7:0]           irqSet;
    logic                 convStart;
    logic                 popReq;
    logic                 fifoClr;
  } daqc_state_t;

  localparam daqc_bus_out_t BUS_RESET = '{ad: 32'h0000_0000, adOe: 1'b0, trdyN: 1'b1,
                                          devselN: 1'b1, stopN: 1'b1, ctlOe: 1'b0};

endpackage

/* File: rtl/daqc_card_regs.sv */
// Sample queue and bus-side register block of the acquisition card.
// Assumes the bus target pins are resolved outside from the enables and
// that all pin inputs are synchronous to clk_sys.
`timescale 1ns/1ps

// ****************************************************************
// Sample queue
// ****************************************************************
module daqc_sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     clr,
  input  wire logic                     inValid,
  input  wire logic [WIDTH-1:0]         inData,
  input  wire logic                     outReady,
  output logic                          inReady,
  output logic                          outValid,
  output logic [WIDTH-1:0]              outData,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 count;
    logic                        notFull;
  } daqc_fifo_state_t;

  daqc_fifo_state_t s_reg;    // Registered queue state
  daqc_fifo_state_t s_next;   // Next queue state
  logic             push;     // Word accepted this cycle
  logic             pop;      // Word taken this cycle

  assign push     = inValid && s_reg.notFull;
  assign pop      = outReady && (s_reg.count != '0);
  assign inReady  = s_reg.notFull;
  assign outValid = (s_reg.count != '0);
  assign outData  = s_reg.mem[s_reg.rdPtr];
  assign level    = s_reg.count;

  // Pointer and count update; clear wins over traffic
  always_comb begin
    s_next = s_reg;
    if (clr) begin
      s_next.wrPtr   = '0;
      s_next.rdPtr   = '0;
      s_next.count   = '0;
      s_next.notFull = 1'b1;
    end else begin
      if (push) begin
        s_next.mem[s_reg.wrPtr] = inData;
        s_next.wrPtr = s_reg.wrPtr + 1'b1;
      end
      if (pop) begin
        s_next.rdPtr = s_reg.rdPtr + 1'b1;
      end
      case ({push, pop})
        2'b10:   s_next.count = s_reg.count + 1'b1;
        2'b01:   s_next.count = s_reg.count - 1'b1;
        default: s_next.count = s_reg.count;
      endcase
      s_next.notFull = (s_next.count != (AW+1)'(DEPTH));
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '{mem: '0, wrPtr: '0, rdPtr: '0, count: '0, notFull: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// Overview of operation
// - Claim 32-bit target cycles at base window
// - Only full-word writes take effect
// - Counter ports and mode word at 0x00-0x0C
// - Result, analog outs, status, digital ports
// - Write-only strobes, setups, queue clear; irq reads back
// - Three 16-bit down counters, one and two chained
// - Counter one output clocks counter two
// - Counter zero clock internal or external pin
// - Pacer pair on time base, external gate
// - Result word read-only, upper half zero
// - Channel in bits 3-0, result 15-4
// - Result bits in straight positional order
// - Pacer time base is 4 MHz
// - Samples queue before the result register
module daqc_card_regs
  import daqc_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire daqc_bus_in_t  busIn,
  input  wire logic [25:0]   baseAddr,
  output daqc_bus_out_t      busOut,
  input  wire logic          sampleValid,
  input  wire logic [11:0]   sampleResult,
  input  wire logic [3:0]    sample_source_channel,
  output logic               sampleReady,
  input  wire logic          ext_trigger_clock_in,
  input  wire logic          ext_pacer_gate_in,
  input  wire logic [3:0]    digitalIn,
  output logic [3:0]         digitalOut,
  output logic [11:0]        analogOutOne,
  output logic [11:0]        analogOutTwo,
  output logic [7:0]         convControl,
  output logic [15:0]        gainChannel,
  output logic [7:0]         burstCount,
  output logic [7:0]         scanSetup,
  output logic [7:0]         convFunction,
  output logic               convStart,
  output logic               counterZeroOut
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  daqc_state_t           s_reg;      // Whole block state
  daqc_state_t           s_next;     // Next state
  logic                  fifoValid;  // Queue holds a sample
  logic [15:0]           fifoData;   // Queue head
  logic [FIFO_LW-1:0]    fifoLevel;  // Queue fill
  logic [15:0]           sampleWord; // Packed sample
  logic                  hit;        // Address phase claims us
  logic                  done;       // Data phase completes
  logic                  fullWr;     // Completed full-word write
  logic [2:0]            cntEn;      // Count enables
  logic                  pacerGate;  // Gate of the pacer pair

  // Channel low, result high, msb on top
  assign sampleWord = {sampleResult, sample_source_channel};

  // Samples wait here until read through the result register
  daqc_sample_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .clr      (s_reg.fifoClr),
    .inValid  (sampleValid),
    .inData   (sampleWord),
    .outReady (s_reg.popReq),
    .inReady  (sampleReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .level    (fifoLevel)
  );

  // ****************************************************************
  // Read data selection
  // ****************************************************************
  function automatic logic [31:0] readMux(input logic [5:0] off, input daqc_state_t s,
                                          input logic fv, input logic [15:0] fd,
                                          input logic [FIFO_LW-1:0] lv,
                                          input logic [3:0] din);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (off)
      OFF_CNT0:   r = {16'h0000, s.cnt[0]};
      OFF_CNT1:   r = {16'h0000, s.cnt[1]};
      OFF_CNT2:   r = {16'h0000, s.cnt[2]};
      OFF_RESULT: r = fv ? {16'h0000, fd} : 32'h0000_0000;
      OFF_STAT: begin
        r[ST_NEMPTY] = fv;
        r[ST_NHFULL] = (lv < FIFO_LW'(FIFO_DEPTH / 2));
        r[ST_NFULL]  = (lv != FIFO_LW'(FIFO_DEPTH));
      end
      OFF_DIO:    r = {28'h0000000, din};
      OFF_IRQ:    r = {24'h000000, s.irqSet};
      default:    r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // One counter step: reload on terminal count and pulse
  function automatic logic [16:0] countStep(input logic [15:0] c, input logic [15:0] rl);
    logic [16:0] r;
    r = {1'b0, c - 16'h0001};
    if (c == 16'h0001) begin
      r = {1'b1, rl};
    end
    return r;
  endfunction

  // Claim test and completion strobe
  assign hit = (s_reg.st == ST_IDLE) && !busIn.frameN && (busIn.ad[31:6] == baseAddr)
               && (busIn.cbeN == CMD_IORD || busIn.cbeN == CMD_IOWR
                   || busIn.cbeN == CMD_MRD || busIn.cbeN == CMD_MWR);
  assign done   = (s_reg.st == ST_XFER) && !busIn.irdyN;
  assign fullWr = done && s_reg.wr && (busIn.cbeN == 4'h0);

  // Pacer gate and count enables
  assign pacerGate = s_reg.ctl[CTL_EXTG] ? ext_pacer_gate_in : s_reg.ctl[CTL_SOFTG];
  assign cntEn[0]  = s_reg.func[FUNC_C0EXT] ? (ext_trigger_clock_in && !s_reg.extPrev)
                                            : s_reg.tbTick;
  assign cntEn[1]  = s_reg.tbTick && pacerGate;
  assign cntEn[2]  = s_reg.pulse[1] && pacerGate;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic [16:0] step;
    step = 17'h00000;
    s_next = s_reg;
    s_next.popReq    = 1'b0;
    s_next.fifoClr   = 1'b0;
    s_next.convStart = 1'b0;
    s_next.extPrev   = ext_trigger_clock_in;
    s_next.pulse     = 3'b000;

    // Time base divider
    s_next.tbTick = (s_reg.tbDiv == TB_DIV - 5'd1);
    s_next.tbDiv  = s_next.tbTick ? 5'd0 : s_reg.tbDiv + 5'd1;

    // Counters
    for (int i = 0; i < 3; i++) begin
      if (cntEn[i] && s_reg.armed[i]) begin
        step = countStep(s_reg.cnt[i], s_reg.reload[i]);
        s_next.cnt[i]   = step[15:0];
        s_next.pulse[i] = step[16];
      end
    end
    if (s_next.pulse[0]) begin
      s_next.c0Out = !s_reg.c0Out;
    end

    // Conversion trigger source
    if (s_reg.ctl[CTL_TMRTR]) begin
      s_next.convStart = s_reg.pulse[2];
    end

    // Bus target sequence
    case (s_reg.st)
      ST_IDLE: begin
        if (hit) begin
          s_next.st  = ST_SEL;
          s_next.wr  = busIn.cbeN[0];
          s_next.off = {busIn.ad[5:2], 2'b00};
          s_next.bus.devselN = 1'b0;
          s_next.bus.ctlOe   = 1'b1;
        end
      end
      ST_SEL: begin
        s_next.st = ST_XFER;
        s_next.bus.trdyN = 1'b0;
        s_next.bus.stopN = 1'b0;
        if (!s_reg.wr) begin
          s_next.bus.adOe = 1'b1;
          s_next.bus.ad = readMux(s_reg.off, s_reg, fifoValid, fifoData, fifoLevel,
                                  digitalIn);
        end
      end
      ST_XFER: begin
        if (done) begin
          s_next.bus.trdyN = 1'b1;
          s_next.bus.adOe  = 1'b0;
          s_next.st = busIn.frameN ? ST_TURN : ST_HOLD;
          if (busIn.frameN) begin
            s_next.bus.devselN = 1'b1;
            s_next.bus.stopN   = 1'b1;
          end
          if (!s_reg.wr && s_reg.off == OFF_RESULT) begin
            s_next.popReq = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        if (busIn.frameN) begin
          s_next.st = ST_TURN;
          s_next.bus.devselN = 1'b1;
          s_next.bus.stopN   = 1'b1;
        end
      end
      ST_TURN: begin
        s_next.st = ST_IDLE;
        s_next.bus.ctlOe = 1'b0;
      end
      default: begin
        s_next.st  = ST_IDLE;
        s_next.bus = BUS_RESET;
      end
    endcase

    // Register writes
    if (fullWr) begin
      case (s_reg.off)
        OFF_CNT0, OFF_CNT1, OFF_CNT2: begin
          s_next.cnt[s_reg.off[3:2]]    = busIn.ad[15:0];
          s_next.reload[s_reg.off[3:2]] = busIn.ad[15:0];
          s_next.armed[s_reg.off[3:2]]  = 1'b1;
        end
        OFF_TMODE: begin
          if (busIn.ad[7:6] != 2'b11) begin
            s_next.mode[busIn.ad[7:6]]  = busIn.ad[5:0];
            s_next.armed[busIn.ad[7:6]] = 1'b0;
          end
        end
        OFF_RESULT:   s_next.daOne  = busIn.ad[11:0];
        OFF_DA2:      s_next.daTwo  = busIn.ad[11:0];
        OFF_STAT:     s_next.ctl    = busIn.ad[7:0];
        OFF_DIO:      s_next.dout   = busIn.ad[3:0];
        OFF_SOFTTRIG: s_next.convStart = !s_reg.ctl[CTL_TMRTR];
        OFF_GAIN:     s_next.gain   = busIn.ad[15:0];
        OFF_BURST:    s_next.burst  = busIn.ad[7:0];
        OFF_SCAN:     s_next.scan   = busIn.ad[7:0];
        OFF_FUNC:     s_next.func   = busIn.ad[7:0];
        OFF_FCLR:     s_next.fifoClr = 1'b1;
        OFF_IRQ:      s_next.irqSet = busIn.ad[7:0];
        default:      s_next.irqSet = s_reg.irqSet;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg     <= '0;
      s_reg.st  <= ST_IDLE;
      s_reg.bus <= BUS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state
  assign busOut         = s_reg.bus;
  assign digitalOut     = s_reg.dout;
  assign analogOutOne   = s_reg.daOne;
  assign analogOutTwo   = s_reg.daTwo;
  assign convControl    = s_reg.ctl;
  assign gainChannel    = s_reg.gain;
  assign burstCount     = s_reg.burst;
  assign scanSetup      = s_reg.scan;
  assign convFunction   = s_reg.func;
  assign convStart      = s_reg.convStart;
  assign counterZeroOut = s_reg.c0Out;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_claim;
    hit;
  endsequence
  sequence s_dataPhase;
    !busOut.devselN ##1 (!busOut.trdyN && !busOut.stopN);
  endsequence

  property p_claim;
    @(posedge clk_sys) disable iff (rst) s_claim |=> s_dataPhase;
  endproperty
  a_claim: assert property (p_claim) else $error("claim not followed by data phase");

  property p_partialIgnored;
    @(posedge clk_sys) disable iff (rst)
      (done && s_reg.wr && busIn.cbeN != 4'h0) |=> $stable(digitalOut) && $stable(convControl);
  endproperty
  a_partialIgnored: assert property (p_partialIgnored) else $error("partial write took effect");

  property p_counterLoad;
    @(posedge clk_sys) disable iff (rst)
      (fullWr && s_reg.off == OFF_CNT1) |=> s_reg.cnt[1] == $past(busIn.ad[15:0]);
  endproperty
  a_counterLoad: assert property (p_counterLoad) else $error("counter one load lost");

  property p_dioWrite;
    @(posedge clk_sys) disable iff (rst)
      (fullWr && s_reg.off == OFF_DIO) |=> digitalOut == $past(busIn.ad[3:0]);
  endproperty
  a_dioWrite: assert property (p_dioWrite) else $error("digital out not written");

  property p_softTrig;
    @(posedge clk_sys) disable iff (rst)
      (fullWr && s_reg.off == OFF_SOFTTRIG && !s_reg.ctl[CTL_TMRTR]) |=> convStart ##1 !convStart;
  endproperty
  a_softTrig: assert property (p_softTrig) else $error("soft trigger pulse wrong");

  property p_chain;
    @(posedge clk_sys) disable iff (rst) s_reg.pulse[2] |-> $past(s_reg.pulse[1]);
  endproperty
  a_chain: assert property (p_chain) else $error("counter two stepped without counter one");

  property p_timebase;
    @(posedge clk_sys) disable iff (rst) s_reg.tbTick |=> !s_reg.tbTick [*8];
  endproperty
  a_timebase: assert property (p_timebase) else $error("time base ticks too fast");

  property p_resultWord;
    @(posedge clk_sys) disable iff (rst)
      (s_reg.st == ST_SEL && !s_reg.wr && s_reg.off == OFF_RESULT && fifoValid)
        |=> busOut.ad == {16'h0000, $past(fifoData)};
  endproperty
  a_resultWord: assert property (p_resultWord) else $error("result word packing wrong");

  property p_woRead;
    @(posedge clk_sys) disable iff (rst)
      (s_reg.st == ST_SEL && !s_reg.wr && s_reg.off == OFF_GAIN)
        |=> busOut.ad == 32'h0000_0000 ##1 $stable(gainChannel);
  endproperty
  a_woRead: assert property (p_woRead) else $error("write-only read not zero");

  property p_fifoClear;
    @(posedge clk_sys) disable iff (rst)
      (fullWr && s_reg.off == OFF_FCLR) |=> ##1 fifoLevel == '0;
  endproperty
  a_fifoClear: assert property (p_fifoClear) else $error("queue clear failed");

endmodule

/* File: tb/daqc_host_model.sv */
// Bus master model facing the card register block.
// Assumes one data phase per access and a free-running clk_sys.
`timescale 1ns/1ps
module daqc_host_model
  import daqc_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire daqc_bus_out_t busOut,
  input  wire logic [25:0]   baseAddr,
  output daqc_bus_in_t       busIn,
  output logic               hung
);
  daqc_bus_in_t drv;     // Master strobes
  logic [31:0]  hostAd;  // Master drive on AD
  // Resolved AD lines: target wins while it drives
  always_comb begin
    busIn    = drv;
    busIn.ad = busOut.adOe ? busOut.ad : hostAd;
  end
  initial begin
    drv    = '{frameN: 1'b1, irdyN: 1'b1, cbeN: 4'hF, ad: 32'h0};
    hostAd = 32'h0;
    hung   = 1'b0;
  end
  // One access: address phase, one data phase, then wait for idle
  task automatic access(input logic wr, input logic [5:0] off, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd);
    int n;
    rd = 32'h0;
    @(posedge clk_sys);
    drv.frameN <= 1'b0;
    drv.cbeN   <= wr ? CMD_MWR : CMD_MRD;
    hostAd     <= {baseAddr, off};
    @(posedge clk_sys);
    drv.frameN <= 1'b1;
    drv.irdyN  <= 1'b0;
    drv.cbeN   <= be;
    hostAd     <= wr ? wd : ~hostAd;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (busOut.trdyN !== 1'b0 && n < 20);
    rd = busIn.ad;
    hung |= (n >= 20);
    // Released lines show the inverse, never the stale value
    drv.irdyN <= 1'b1;
    drv.cbeN  <= 4'hF;
    hostAd    <= ~busIn.ad;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (busOut.ctlOe !== 1'b0 && n < 20);
    hung |= (n >= 20);
  endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench of the card register block.
// Assumes the host model drives the bus; pins are driven here.
`timescale 1ns/1ps
module tb_top
  import daqc_pkg::*;
;
  logic clk_sys = 1'b0, rst = 1'b1, sampleValid = 1'b0, extClk = 1'b0, extGate = 1'b0;
  logic [25:0] baseAddr = 26'h2ABCDE1;
  logic [11:0] sampleResult = 12'h000, daOne, daTwo;
  logic [3:0] sampleChan = 4'h0, digitalIn = 4'hA, digitalOut;
  logic [7:0] ctl, burst, scan, func;
  logic [15:0] gain;
  logic sampleReady, convStart, c0Out, c0Prev, hung;
  daqc_bus_in_t  busIn;
  daqc_bus_out_t busOut;
  int failures = 0, checks = 0, pulses = 0, toggles = 0, p0;
  logic [31:0] rd;
  logic [5:0] wo[8] = '{OFF_TMODE, OFF_DA2, OFF_SOFTTRIG, OFF_GAIN, OFF_BURST, OFF_SCAN,
                        OFF_FUNC, OFF_FCLR};
  always #5 clk_sys = ~clk_sys;
  // Event counters for pulses and counter zero toggles
  always @(posedge clk_sys) begin
    pulses  += (convStart === 1'b1);
    toggles += (c0Out !== c0Prev);
    c0Prev  = c0Out;
  end
  daqc_host_model i_host (.clk_sys(clk_sys), .busOut(busOut), .baseAddr(baseAddr),
                          .busIn(busIn), .hung(hung));
  daqc_card_regs i_dut (.clk_sys(clk_sys), .rst(rst), .busIn(busIn), .baseAddr(baseAddr),
    .busOut(busOut), .sampleValid(sampleValid), .sampleResult(sampleResult),
    .sample_source_channel(sampleChan), .sampleReady(sampleReady),
    .ext_trigger_clock_in(extClk), .ext_pacer_gate_in(extGate), .digitalIn(digitalIn),
    .digitalOut(digitalOut), .analogOutOne(daOne), .analogOutTwo(daTwo), .convControl(ctl),
    .gainChannel(gain), .burstCount(burst), .scanSetup(scan), .convFunction(func),
    .convStart(convStart), .counterZeroOut(c0Out));
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] off, input logic [31:0] d);
    logic [31:0] x;
    i_host.access(1'b1, off, 4'h0, d, x);
    if (hung) complete_run();
  endtask
  task automatic rdr(input logic [5:0] off, output logic [31:0] d);
    i_host.access(1'b0, off, 4'h0, 32'h0, d);
    if (hung) complete_run();
  endtask
  // Writes land on outputs; reads of write-only places give zero
  task automatic t_regs();
    wr(OFF_RESULT, 32'hFFFF_F5A3); wr(OFF_DA2, 32'h0000_0C3C); wr(OFF_STAT, 32'h0000_00C3);
    wr(OFF_DIO, 32'h0000_0009); wr(OFF_GAIN, 32'h0000_BEEF); wr(OFF_BURST, 32'h0000_005A);
    wr(OFF_SCAN, 32'h0000_00A5); wr(OFF_FUNC, 32'h0000_003C); wr(OFF_IRQ, 32'h0000_0077);
    check({daOne, daTwo, ctl}, 32'h5A3C_3CC3, "analog and control");
    check({gain, burst, scan}, 32'hBEEF_5AA5, "setups");
    check({func, 20'h0, digitalOut}, 32'h3C00_0009, "function and dout");
    rdr(OFF_IRQ, rd); check(rd, 32'h0000_0077, "irq read");
    rdr(OFF_DIO, rd); check(rd, 32'h0000_000A, "digital in");
    foreach (wo[i]) begin rdr(wo[i], rd); check(rd, 32'h0, "write-only read"); end
    i_host.access(1'b1, OFF_DIO, 4'h1, 32'h6, rd);
    check({28'h0, digitalOut}, 32'h9, "narrow write ignored");
    $display("t_regs done");
  endtask
  // Samples pass the queue and come back packed
  task automatic t_result();
    sampleValid <= 1'b1; sampleResult <= 12'hABC; sampleChan <= 4'h5;
    @(posedge clk_sys); sampleResult <= 12'h123; sampleChan <= 4'hE;
    @(posedge clk_sys); sampleValid <= 1'b0;
    rdr(OFF_STAT, rd); check(rd[ST_NEMPTY], 1'b1, "not empty");
    rdr(OFF_RESULT, rd); check(rd, 32'h0000_ABC5, "first word");
    rdr(OFF_RESULT, rd); check(rd, 32'h0000_123E, "second word");
    rdr(OFF_STAT, rd); check(rd[ST_NEMPTY], 1'b0, "drained");
    sampleValid <= 1'b1;
    @(posedge clk_sys); sampleValid <= 1'b0;
    wr(OFF_FCLR, 32'h0);
    rdr(OFF_RESULT, rd); check(rd, 32'h0, "cleared queue");
    $display("t_result done");
  endtask
  // Software strobe, pacer gates and counter zero clock
  task automatic t_timer();
    p0 = pulses; wr(OFF_SOFTTRIG, 32'h0); check(pulses - p0, 1, "soft strobe");
    wr(OFF_CNT1, 32'h2); wr(OFF_CNT2, 32'h2); wr(OFF_STAT, 32'h24);
    p0 = pulses; repeat (1000) @(posedge clk_sys);
    check(32'((pulses - p0) inside {[8:12]}), 1, "pacer rate");
    // Let a pulse already in the chain drain before counting
    wr(OFF_STAT, 32'h14); repeat (4) @(posedge clk_sys);
    p0 = pulses; repeat (500) @(posedge clk_sys);
    check(pulses - p0, 0, "gate low");
    extGate <= 1'b1; repeat (500) @(posedge clk_sys);
    check(32'(pulses - p0 >= 4), 1, "gate high");
    wr(OFF_STAT, 32'h0); wr(OFF_FUNC, 32'h1); wr(OFF_CNT0, 32'h2);
    p0 = toggles; repeat (200) @(posedge clk_sys);
    check(toggles - p0, 0, "no ext edges");
    repeat (16) begin @(posedge clk_sys); extClk <= ~extClk; repeat (3) @(posedge clk_sys); end
    check(32'((toggles - p0) inside {[3:4]}), 1, "ext clocked");
    // Mode word for counter zero stops it until its port is written again
    wr(OFF_TMODE, 32'h0); p0 = toggles;
    repeat (8) begin @(posedge clk_sys); extClk <= ~extClk; repeat (3) @(posedge clk_sys); end
    check(toggles - p0, 0, "mode word stops");
    // Internal time base: terminal every two ticks of 25 cycles
    wr(OFF_FUNC, 32'h0); wr(OFF_CNT0, 32'h2); p0 = toggles;
    repeat (400) @(posedge clk_sys);
    check(32'((toggles - p0) inside {[7:9]}), 1, "internal clock");
    $display("t_timer done");
  endtask
  task automatic complete_run();
    if (hung) failures++;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check({busOut.devselN, sampleReady, digitalOut}, 32'h30, "reset values");
    t_regs();
    t_result();
    t_timer();
    complete_run();
  end
endmodule
